// File: shared/pfm_defines.vh
`ifndef PFM_DEFINES_VH
`define PFM_DEFINES_VH

// APB byte offsets
`define PFM_OFF_PER_EN     12'h000
`define PFM_OFF_PER_SEL    12'h004
`define PFM_OFF_GPIO_DIR   12'h008
`define PFM_OFF_GPIO_OUT   12'h00C
`define PFM_OFF_GPIO_IN    12'h010
`define PFM_OFF_RST_CTRL   12'h014
`define PFM_OFF_STATUS     12'h018

// Peripheral enable bits, one per pin
`define PFM_PIN_COUNT      6
`define PFM_PER_EN_RST     6'h00

// Peripheral select field layout: two bits per pin
`define PFM_SEL_W          2
`define PFM_PER_SEL_RST    12'h000
`define PFM_GPIO_DIR_RST   6'h00
`define PFM_GPIO_OUT_RST   6'h00

// Reset pin control: bit 0 masks the reset pin as a reset source
`define PFM_RST_CTRL_GPIO_BIT 0
`define PFM_RST_CTRL_SWRST_BIT 1

// Reset release stretch
`define PFM_RST_HOLD_CYCLES 32

// Select codes per pin
`define PFM_SEL_P4_CRYSTAL 2'h0
`define PFM_SEL_P4_CLKIN   2'h1
`define PFM_SEL_P5_TX      2'h0
`define PFM_SEL_P5_XBOUT   2'h1
`define PFM_SEL_P5_XBIN    2'h2
`define PFM_SEL_P5_CLKO    2'h3
`define PFM_SEL_P6_RX      2'h0
`define PFM_SEL_P6_XBOUT   2'h1
`define PFM_SEL_P6_CMP     2'h2
`define PFM_SEL_P6_PWM     2'h3

`endif

// File: rtl/pfm_reset_stretch.v
`timescale 1ns/1ns
`include "pfm_defines.vh"

module pfm_reset_stretch #(
  parameter HOLD_CYCLES = `PFM_RST_HOLD_CYCLES
) (
  input  wire pclk,
  input  wire presetn,
  input  wire reset_request,
  output wire sys_reset_n
);

  reg [7:0] count_q;
  reg       release_q;

  // Counter restarts on every request so release is always a full hold later
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q   <= 8'h00;
      release_q <= 1'b0;
    end else if (reset_request) begin
      count_q   <= 8'h00;
      release_q <= 1'b0;
    end else if (count_q != HOLD_CYCLES[7:0]) begin
      count_q   <= count_q + 8'h01;
      release_q <= 1'b0;
    end else begin
      release_q <= 1'b1;
    end
  end

  assign sys_reset_n = release_q;

endmodule

// File: rtl/pfm_pin_mux.v
// Chosen here: the APB register port and the address map.
`timescale 1ns/1ns
`include "pfm_defines.vh"
// Functional notes
// - Pins come up in primary function; alternatives need both enable and select. Here pins 0, 1 and 3 switch on enable alone.
// - Each pin in port mode has its own software direction bit.
// - Pin one defaults to test clock input; alternative is port D bit two.
// - Reset pin low resets device; release synchronous after fixed cycle count.
// - Reset pin as port pin disables pin reset; only other resets remain. Here only rst_gpio_q disables it; port mode does not.
// - Crystal input pin defaults to port; alternatives crystal input, clock input zero.
// - Crystal output pin defaults to port; alternative is crystal output.
// - Pin five offers serial transmit, crossbar out 11, crossbar in 2, clock out.
// - Pin six offers serial receive, crossbar out 10, comparator D, PWM aux.

module pfm_pin_mux (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire [5:0]  pad_in,
  output reg  [5:0]  pad_out,
  output reg  [5:0]  pad_oe,
  input  wire        por_reset,
  input  wire        watchdog_reset,
  output wire        sys_reset_n,
  output wire        test_clock_in,
  input  wire        crystal_output,
  output wire        crystal_input,
  output wire        ext_clock_input_zero,
  input  wire        serial0_transmit,
  input  wire        serial0_transmit_oe,
  output wire        serial0_transmit_in,
  input  wire        crossbar_output_eleven,
  output wire        crossbar_input_two,
  input  wire        buffered_clock_out_zero,
  output wire        serial0_receive,
  input  wire        crossbar_output_ten,
  input  wire        comparator_d_output,
  input  wire        pwm_sub2_aux_channel,
  input  wire        pwm_sub2_aux_channel_oe,
  output wire        pwm_sub2_aux_capture
);

  localparam N = `PFM_PIN_COUNT;
  localparam SW = `PFM_SEL_W;

  reg  [N-1:0]    per_en_q;
  reg  [N*SW-1:0] per_sel_q;
  reg  [N-1:0]    gpio_dir_q;
  reg  [N-1:0]    gpio_out_q;
  reg  [N-1:0]    gpio_in_q;
  reg             rst_gpio_q;
  reg             sw_reset_q;
  reg  [N-1:0]    alt_out;
  reg  [N-1:0]    alt_oe;
  wire            wr_en;
  wire            rd_en;
  wire            addr_hit;
  wire [1:0]      sel5;
  wire [1:0]      sel6;
  wire [1:0]      sel3;
  wire            reset_request;

  assign pready   = 1'b1;
  assign addr_hit = (paddr == `PFM_OFF_PER_EN)   || (paddr == `PFM_OFF_PER_SEL) ||
                    (paddr == `PFM_OFF_GPIO_DIR) || (paddr == `PFM_OFF_GPIO_OUT) ||
                    (paddr == `PFM_OFF_GPIO_IN)  || (paddr == `PFM_OFF_RST_CTRL) ||
                    (paddr == `PFM_OFF_STATUS);
  assign pslverr  = psel & penable & ~addr_hit;
  assign wr_en    = psel & penable & pwrite & addr_hit;
  assign rd_en    = psel & ~penable & ~pwrite;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      per_en_q   <= `PFM_PER_EN_RST;
      per_sel_q  <= `PFM_PER_SEL_RST;
      gpio_dir_q <= `PFM_GPIO_DIR_RST;
      gpio_out_q <= `PFM_GPIO_OUT_RST;
      rst_gpio_q <= 1'b0;
      sw_reset_q <= 1'b0;
    end else if (!sys_reset_n) begin
      // Pin configuration returns to defaults while the stretched reset holds
      per_en_q   <= `PFM_PER_EN_RST;
      per_sel_q  <= `PFM_PER_SEL_RST;
      gpio_dir_q <= `PFM_GPIO_DIR_RST;
      gpio_out_q <= `PFM_GPIO_OUT_RST;
      rst_gpio_q <= 1'b0;
      sw_reset_q <= 1'b0;
    end else if (wr_en) begin
      case (paddr)
        `PFM_OFF_PER_EN:   per_en_q   <= pwdata[N-1:0];
        `PFM_OFF_PER_SEL:  per_sel_q  <= pwdata[N*SW-1:0];
        `PFM_OFF_GPIO_DIR: gpio_dir_q <= pwdata[N-1:0];
        `PFM_OFF_GPIO_OUT: gpio_out_q <= pwdata[N-1:0];
        `PFM_OFF_RST_CTRL: begin
          rst_gpio_q <= pwdata[`PFM_RST_CTRL_GPIO_BIT];
          sw_reset_q <= pwdata[`PFM_RST_CTRL_SWRST_BIT];
        end
        default: ;
      endcase
    end
  end

  // Read data registered in setup phase so the access phase answers with zero wait
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (rd_en) begin
      case (paddr)
        `PFM_OFF_PER_EN:   prdata <= {26'h0, per_en_q};
        `PFM_OFF_PER_SEL:  prdata <= {20'h0, per_sel_q};
        `PFM_OFF_GPIO_DIR: prdata <= {26'h0, gpio_dir_q};
        `PFM_OFF_GPIO_OUT: prdata <= {26'h0, gpio_out_q};
        `PFM_OFF_GPIO_IN:  prdata <= {26'h0, gpio_in_q};
        `PFM_OFF_RST_CTRL: prdata <= {30'h0, sw_reset_q, rst_gpio_q};
        `PFM_OFF_STATUS:   prdata <= {26'h0, per_en_q & ~gpio_dir_q};
        default:           prdata <= 32'h00000000;
      endcase
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gpio_in_q <= 6'h00;
    end else begin
      gpio_in_q <= pad_in;
    end
  end

  assign sel3 = per_sel_q[2*SW+1:2*SW];
  assign sel5 = per_sel_q[4*SW+1:4*SW];
  assign sel6 = per_sel_q[5*SW+1:5*SW];

  // Pin index: 0 test clock, 1 reset, 2 crystal in, 3 crystal out, 4 pin five, 5 pin six
  always @* begin
    alt_out = 6'h00;
    alt_oe  = 6'h00;
    alt_out[3] = crystal_output;
    alt_oe[3]  = 1'b1;
    case (sel5)
      `PFM_SEL_P5_TX: begin
        alt_out[4] = serial0_transmit;
        alt_oe[4]  = serial0_transmit_oe;
      end
      `PFM_SEL_P5_XBOUT: begin
        alt_out[4] = crossbar_output_eleven;
        alt_oe[4]  = 1'b1;
      end
      `PFM_SEL_P5_CLKO: begin
        alt_out[4] = buffered_clock_out_zero;
        alt_oe[4]  = 1'b1;
      end
      default: alt_oe[4] = 1'b0;
    endcase
    case (sel6)
      `PFM_SEL_P6_XBOUT: begin
        alt_out[5] = crossbar_output_ten;
        alt_oe[5]  = 1'b1;
      end
      `PFM_SEL_P6_CMP: begin
        alt_out[5] = comparator_d_output;
        alt_oe[5]  = 1'b1;
      end
      `PFM_SEL_P6_PWM: begin
        alt_out[5] = pwm_sub2_aux_channel;
        alt_oe[5]  = pwm_sub2_aux_channel_oe;
      end
      default: alt_oe[5] = 1'b0;
    endcase
  end

  // Pins 0 and 1 have a primary function that is an input; enable switches them to port mode.
  // Pins 2..5 come up as port pins; enable switches them to the selected alternative.
  genvar i;
  generate
    for (i = 0; i < N; i = i + 1) begin : g_pin
      wire port_mode;
      if (i < 2) begin : g_prim_in
        assign port_mode = per_en_q[i];
      end else begin : g_prim_port
        assign port_mode = ~per_en_q[i];
      end
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          pad_out[i] <= 1'b0;
          pad_oe[i]  <= 1'b0;
        end else if (port_mode) begin
          pad_out[i] <= gpio_out_q[i];
          pad_oe[i]  <= gpio_dir_q[i];
        end else if (i < 2) begin
          pad_out[i] <= 1'b0;
          pad_oe[i]  <= 1'b0;
        end else begin
          pad_out[i] <= alt_out[i];
          pad_oe[i]  <= alt_oe[i];
        end
      end
    end
  endgenerate

  assign test_clock_in        = ~per_en_q[0] & pad_in[0];
  assign crystal_input        = per_en_q[2] & (sel3 == `PFM_SEL_P4_CRYSTAL) & pad_in[2];
  assign ext_clock_input_zero = per_en_q[2] & (sel3 == `PFM_SEL_P4_CLKIN) & pad_in[2];
  assign serial0_transmit_in  = per_en_q[4] & (sel5 == `PFM_SEL_P5_TX) & pad_in[4];
  assign crossbar_input_two   = per_en_q[4] & (sel5 == `PFM_SEL_P5_XBIN) & pad_in[4];
  assign serial0_receive      = per_en_q[5] & (sel6 == `PFM_SEL_P6_RX) & pad_in[5];
  assign pwm_sub2_aux_capture = per_en_q[5] & (sel6 == `PFM_SEL_P6_PWM) & pad_in[5];

  // Pin reset is ignored while rst_gpio_q is set; power-on, watchdog and software resets stay live
  assign reset_request = (~rst_gpio_q & ~pad_in[1]) | por_reset | watchdog_reset |
                         sw_reset_q;

  pfm_reset_stretch #(
    .HOLD_CYCLES (`PFM_RST_HOLD_CYCLES)
  ) u_rst (
    .pclk          (pclk),
    .presetn       (presetn),
    .reset_request (reset_request),
    .sys_reset_n   (sys_reset_n)
  );

endmodule

// File: testbench/pfm_pin_mux_props.sv
`timescale 1ns/1ns
`include "pfm_defines.vh"
module pfm_pin_mux_props (
  input wire       pclk,
  input wire       presetn,
  input wire [5:0] pad_in,
  input wire [5:0] pad_oe,
  input wire       por_reset,
  input wire       watchdog_reset,
  input wire       sys_reset_n,
  input wire       test_clock_in,
  input wire       crystal_input,
  input wire       ext_clock_input_zero,
  input wire       crossbar_input_two,
  input wire       serial0_receive
);
  localparam int HOLD = `PFM_RST_HOLD_CYCLES;
  logic [7:0] lo_cnt;
  // Saturates so a long pin reset cannot wrap the count
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) lo_cnt <= 8'h00;
    else if (sys_reset_n) lo_cnt <= 8'h00;
    else if (!lo_cnt[7]) lo_cnt <= lo_cnt + 8'h01;
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_HOLD: assert property ($rose(sys_reset_n) |-> lo_cnt >= HOLD)
    else $error("internal reset released early");
  AST_POR: assert property (por_reset |-> ##[1:3] !sys_reset_n)
    else $error("power-on reset ignored");
  AST_WDOG: assert property (watchdog_reset |-> ##[1:3] !sys_reset_n)
    else $error("watchdog reset ignored");
  AST_DEFOE: assert property (!sys_reset_n [*2] |=> pad_oe == 6'h00)
    else $error("pad driven during reset");
  AST_TCK: assert property (!sys_reset_n [*2] |-> test_clock_in == pad_in[0])
    else $error("pin one not on test clock after reset");
  AST_GATE: assert property (({test_clock_in, crystal_input, crossbar_input_two,
    serial0_receive} & ~{pad_in[0], pad_in[2], pad_in[4], pad_in[5]}) == 4'h0
    && !(crystal_input && ext_clock_input_zero))
    else $error("input function not taken from its pad");
  AST_CLKIN: assert property (ext_clock_input_zero && $past(ext_clock_input_zero)
    |-> !pad_oe[2])
    else $error("clock input pin driven");
  AST_XBIN: assert property (crossbar_input_two && $past(crossbar_input_two)
    |-> !pad_oe[4])
    else $error("crossbar input pin driven");
  AST_RXIN: assert property (serial0_receive && $past(serial0_receive)
    |-> !pad_oe[5])
    else $error("receive pin driven");
endmodule

// File: testbench/pfm_pad_model.sv
`timescale 1ns/1ns
// Board side: a driven pad shows the chip's level, otherwise the board level
module pfm_pad_model (
  input  wire [5:0] pad_out,
  input  wire [5:0] pad_oe,
  input  wire [5:0] board,
  output wire [5:0] pad_in
);
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & board);
endmodule

// File: testbench/pfm_pin_mux_test.sv
`timescale 1ns/1ns
`include "pfm_defines.vh"
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin error_cnt++; \
  $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module pfm_pin_mux_test;
  logic        pclk, presetn, psel, penable, pwrite, por_reset, watchdog_reset;
  logic        pready, pslverr, sys_reset_n, er;
  logic [11:0] paddr, sl;
  logic [31:0] pwdata, prdata, rd;
  logic [5:0]  pad_in, pad_out, pad_oe, board, en, dr, ou, eoe, eo;
  logic [8:0]  pv, pvn;
  logic [4:0]  cin, ec;
  logic [1:0]  cx, ex;
  logic [57:0] rows [9];
  int          error_cnt, cmp_count, cyc, n, i;
  pfm_pin_mux pfm_pin_mux_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .pad_in, .pad_out, .pad_oe, .por_reset,
    .watchdog_reset, .sys_reset_n, .test_clock_in(cin[0]), .crystal_output(pv[8]),
    .crystal_input(cin[4]), .ext_clock_input_zero(cin[3]), .serial0_transmit(pv[7]),
    .serial0_transmit_oe(pv[6]), .serial0_transmit_in(cx[0]), .crossbar_output_eleven(pv[5]),
    .crossbar_input_two(cin[2]), .buffered_clock_out_zero(pv[4]), .serial0_receive(cin[1]),
    .crossbar_output_ten(pv[3]), .comparator_d_output(pv[2]),
    .pwm_sub2_aux_channel(pv[1]), .pwm_sub2_aux_channel_oe(pv[0]), .pwm_sub2_aux_capture(cx[1]));
  pfm_pad_model pfm_pad_model_inst (.pad_out, .pad_oe, .board, .pad_in);
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  task automatic close_out();
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      close_out();
    end
  end
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic wait_up();
    n = 0;
    do begin
      @(posedge pclk);
      #1;
      n++;
    end while (sys_reset_n !== 1'b1 && n < 200);
    // Hand back on a rising edge so the caller drives inputs there
    @(posedge pclk);
  endtask
  // Columns: enable, select, direction, out, peripherals, oe, driven level, inputs, transmit and PWM capture inputs
  initial begin
    rows[0] = {6'h00, 12'h000, 6'h00, 6'h00, 9'h000, 6'h00, 6'h00, 5'h01, 2'h0};
    rows[1] = {6'h03, 12'h000, 6'h3D, 6'h15, 9'h1FF, 6'h3D, 6'h15, 5'h00, 2'h0};
    rows[2] = {6'h3C, 12'h010, 6'h3D, 6'h00, 9'h1C0, 6'h18, 6'h18, 5'h0B, 2'h1};
    rows[3] = {6'h3C, 12'h010, 6'h3D, 6'h00, 9'h000, 6'h08, 6'h00, 5'h0B, 2'h1};
    rows[4] = {6'h3C, 12'h500, 6'h00, 6'h00, 9'h108, 6'h38, 6'h28, 5'h11, 2'h0};
    rows[5] = {6'h3C, 12'hA00, 6'h00, 6'h00, 9'h004, 6'h28, 6'h20, 5'h15, 2'h0};
    rows[6] = {6'h3C, 12'hF00, 6'h00, 6'h00, 9'h110, 6'h18, 6'h18, 5'h11, 2'h2};
    rows[7] = {6'h08, 12'h000, 6'h04, 6'h04, 9'h000, 6'h0C, 6'h04, 5'h01, 2'h0};
    rows[8] = {6'h3C, 12'hF00, 6'h00, 6'h00, 9'h003, 6'h38, 6'h20, 5'h11, 2'h2};
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {por_reset, watchdog_reset, presetn, pv} = '0;
    board = 6'h3F;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    wait_up();
    `CHK(n, `PFM_RST_HOLD_CYCLES + 1)
    `CHK(pad_oe, 6'h00)
    for (i = 0; i < 4; i++) begin
      apb(1'b0, 12'(i * 4), 32'h0);
      `CHK({rd, er}, 33'h0)
    end
    apb(1'b0, 12'h020, 32'h0);
    `CHK({rd, er}, 33'h1)
    board[0] <= 1'b0;
    @(posedge pclk);
    #1;
    `CHK(cin[0], 1'b0)
    @(posedge pclk);
    board[0] <= 1'b1;
    for (i = 0; i < 9; i++) begin
      {en, sl, dr, ou, pvn, eoe, eo, ec, ex} = rows[i];
      apb(1'b1, `PFM_OFF_PER_EN, {26'h0, en});
      apb(1'b1, `PFM_OFF_PER_SEL, {20'h0, sl});
      apb(1'b1, `PFM_OFF_GPIO_DIR, {26'h0, dr});
      apb(1'b1, `PFM_OFF_GPIO_OUT, {26'h0, ou});
      pv <= pvn;
      repeat (3) @(posedge pclk);
      #1;
      `CHK(pad_oe, eoe)
      `CHK(pad_out & eoe, eo)
      `CHK(cin, ec)
      `CHK(cx, ex)
      apb(1'b0, `PFM_OFF_GPIO_IN, 32'h0);
      `CHK(rd[5:0], (eo & eoe) | (board & ~eoe))
      apb(1'b0, `PFM_OFF_STATUS, 32'h0);
      `CHK(rd[5:0], en & ~dr)
    end
    board[1] <= 1'b0;
    repeat (3) @(posedge pclk);
    #1;
    `CHK(sys_reset_n, 1'b0)
    @(posedge pclk);
    board[1] <= 1'b1;
    wait_up();
    apb(1'b0, `PFM_OFF_PER_EN, 32'h0);
    `CHK(rd, 32'h0)
    apb(1'b1, `PFM_OFF_RST_CTRL, 32'h1);
    board[1] <= 1'b0;
    repeat (40) @(posedge pclk);
    #1;
    `CHK(sys_reset_n, 1'b1)
    apb(1'b0, `PFM_OFF_RST_CTRL, 32'h0);
    `CHK(rd, 32'h1)
    // Watchdog, power-on, then software reset; the first runs with the pin reset disabled
    for (i = 0; i < 3; i++) begin
      if (i < 2) {por_reset, watchdog_reset} <= 2'(i + 1);
      else apb(1'b1, `PFM_OFF_RST_CTRL, 32'h2);
      repeat (3) @(posedge pclk);
      #1;
      `CHK(sys_reset_n, 1'b0)
      @(posedge pclk);
      {por_reset, watchdog_reset} <= 2'b00;
      board[1] <= 1'b1;
      wait_up();
    end
    close_out();
  end
endmodule
bind pfm_pin_mux pfm_pin_mux_props pfm_pin_mux_props_inst (.pclk, .presetn, .pad_in, .pad_oe,
  .por_reset, .watchdog_reset, .sys_reset_n, .test_clock_in, .crystal_input,
  .ext_clock_input_zero, .crossbar_input_two, .serial0_receive);
